// >>> verilog/pomgr_pkg.sv
// constants for the phy mode and pin mux register slice
package pomgr_pkg;
   // register indices (printed offsets are not all multiples of four)
   localparam logic [9:0] peak_sign_index = 10'h1a6;
   localparam logic [9:0] mode_index = 10'h1df;
   localparam logic [9:0] pin_mux_index = 10'h1e0;
   localparam logic [11:0] peak_sign_addr = {peak_sign_index, 2'h0};
   localparam logic [11:0] mode_addr = {mode_index, 2'h0};
   localparam logic [11:0] pin_mux_addr = {pin_mux_index, 2'h0};
   // own register for delimiter enables and line energy mode hints
   localparam logic [11:0] sfd_ctrl_addr = 12'h800;
   // reset values
   localparam logic [15:0] mode_reset = 16'h0040;
   localparam logic [15:0] pin_mux_reset = 16'h417a;
   localparam logic [15:0] mode_rw_mask = 16'h0067;
   // field positions
   localparam int peak_c_lsb = 0;
   localparam int peak_d_lsb = 5;
   localparam int opmode_lsb = 0;
   localparam int mii_sel_bit = 5;
   localparam int bridge_bit = 6;
   localparam int pin0_lsb = 0;
   localparam int pin1_lsb = 4;
   localparam int sfd_tx_en_bit = 0;
   localparam int sfd_rx_en_bit = 1;
   localparam int speed_100_bit = 2;
   // operating modes
   localparam logic [2:0] op_rgmii_copper = 3'h0;
   localparam logic [2:0] op_bt_to_bx = 3'h4;
   localparam logic [2:0] op_t100_to_fx = 3'h5;
   localparam logic [2:0] op_sgmii_copper = 3'h6;
   // pin function codes
   localparam logic [3:0] fn_clk_out = 4'h0;
   localparam logic [3:0] fn_intr = 4'h2;
   localparam logic [3:0] fn_link = 4'h3;
   localparam logic [3:0] fn_transmit_delimiter_pulse = 4'h5;
   localparam logic [3:0] fn_receive_delimiter_pulse = 4'h6;
   localparam logic [3:0] fn_wake = 4'h7;
   localparam logic [3:0] fn_energy = 4'h8;
   localparam logic [3:0] fn_prbs = 4'h9;
   localparam logic [3:0] fn_ind2 = 4'ha;
   localparam logic [3:0] fn_ind3 = 4'hb;
   localparam logic [3:0] fn_crs = 4'hc;
   localparam logic [3:0] fn_col = 4'hd;
   localparam logic [3:0] fn_low = 4'he;
   localparam logic [3:0] fn_high = 4'hf;
endpackage

// >>> verilog/pomgr_regs.sv
// management registers for operating mode, peak signs and pin mux
//
// Summary of operation
// - read-only peak signs, D in 9:5, C 4:0
// - opmode field bits 2:0 selects media mode
// - bit 6 bridge direction, resets to one
// - bit 5 selects RGMII or MII, resets zero
// - pin1 select bits 7:4, reset wake code
// - any delimiter enable forces transmit delimiter pin1
// - pin0 select bits 3:0, receive delimiter override
// - pin function code table for both pins
// - energy detect only in copper gigabit/100
//
// The APB slave port was chosen for this implementation.
module pomgr_regs
   import pomgr_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // cable test results
   input wire logic [4:0] pair_c_peak_polarity,
   input wire logic [4:0] pair_d_peak_polarity,
   // pin function sources
   input wire logic clk_out_src,
   input wire logic intr_src,
   input wire logic link_src,
   input wire logic transmit_delimiter_pulse,
   input wire logic receive_delimiter_pulse,
   input wire logic wake_on_lan_output,
   input wire logic energy_src,
   input wire logic prbs_err_src,
   input wire logic second_indicator_output,
   input wire logic third_indicator_output,
   input wire logic crs_src,
   input wire logic col_src,
   // mode outputs
   output logic [2:0] operating_mode_code,
   output logic bridge_direction_sel,
   output logic mii_select,
   // general purpose pins
   output logic pin0_out,
   output logic pin1_out
);
   logic [15:0] mode_reg;
   logic [15:0] mux_reg;
   logic [2:0] sfd_reg;
   logic [9:0] sign_s1;
   logic [9:0] sign_s2;
   logic [11:0] src_s1;
   logic [11:0] src_s2;
   logic wr;
   logic rd;
   logic sfd_any;
   logic energy_ok;
   logic [15:0] rdata;
   logic next_pin0;
   logic next_pin1;

   // ----------------------------------------
   // input synchronisers
   // ----------------------------------------
   always_ff @(posedge clk) begin
      sign_s1 <= {pair_d_peak_polarity, pair_c_peak_polarity};
      sign_s2 <= sign_s1;
      src_s1 <= {col_src, crs_src, third_indicator_output, second_indicator_output, prbs_err_src, energy_src,
                 wake_on_lan_output, receive_delimiter_pulse, transmit_delimiter_pulse, link_src, intr_src,
                 clk_out_src};
      src_s2 <= src_s1;
   end

   // ----------------------------------------
   // bus access, zero wait states
   // ----------------------------------------
   assign wr = psel && penable && pwrite && pready;
   assign rd = psel && !penable && !pwrite;

   always_ff @(posedge clk) begin
      if (reset) begin
         pready <= 1'b0;
      end else begin
         pready <= psel && !penable;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         mode_reg <= mode_reset;
      end else if (wr && paddr == mode_addr) begin
         mode_reg <= pwdata[15:0] & mode_rw_mask;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         mux_reg <= pin_mux_reset;
      end else if (wr && paddr == pin_mux_addr) begin
         mux_reg <= pwdata[15:0];
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         sfd_reg <= 3'h0;
      end else if (wr && paddr == sfd_ctrl_addr) begin
         sfd_reg <= pwdata[2:0];
      end
   end

   always_comb begin
      rdata = 16'h0000;
      unique case (paddr)
         peak_sign_addr: rdata = {6'h00, sign_s2};
         mode_addr: rdata = mode_reg;
         pin_mux_addr: rdata = mux_reg;
         sfd_ctrl_addr: rdata = {13'h0000, sfd_reg};
         default: rdata = 16'h0000;
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (psel && !penable) begin
         prdata <= rd ? {16'h0000, rdata} : 32'h0000_0000;
         pslverr <= !(paddr == peak_sign_addr || paddr == mode_addr || paddr == pin_mux_addr ||
                      paddr == sfd_ctrl_addr) || (pwrite && paddr == peak_sign_addr);
      end
   end

   // ----------------------------------------
   // mode outputs
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         operating_mode_code <= mode_reset[opmode_lsb +: 3];
         bridge_direction_sel <= mode_reset[bridge_bit];
         mii_select <= mode_reset[mii_sel_bit];
      end else begin
         operating_mode_code <= mode_reg[opmode_lsb +: 3];
         bridge_direction_sel <= mode_reg[bridge_bit];
         mii_select <= mode_reg[mii_sel_bit];
      end
   end

   // ----------------------------------------
   // pin multiplexer
   // ----------------------------------------
   assign sfd_any = sfd_reg[sfd_tx_en_bit] || sfd_reg[sfd_rx_en_bit];
   // copper 1000BASE-T or 100BASE-TX only
   assign energy_ok = (mode_reg[opmode_lsb +: 3] == op_rgmii_copper || mode_reg[opmode_lsb +: 3] == op_sgmii_copper ||
                       mode_reg[opmode_lsb +: 3] == op_bt_to_bx ||
                       mode_reg[opmode_lsb +: 3] == op_t100_to_fx);

   function automatic logic pin_pick(input logic [3:0] code, input logic [11:0] s, input logic en_ok);
      logic v;
      v = 1'b0;
      unique case (code)
         fn_clk_out: v = s[0];
         fn_intr: v = s[1];
         fn_link: v = s[2];
         fn_transmit_delimiter_pulse: v = s[3];
         fn_receive_delimiter_pulse: v = s[4];
         fn_wake: v = s[5];
         fn_energy: v = s[6] && en_ok;
         fn_prbs: v = s[7];
         fn_ind2: v = s[8];
         fn_ind3: v = s[9];
         fn_crs: v = s[10];
         fn_col: v = s[11];
         fn_low: v = 1'b0;
         fn_high: v = 1'b1;
         default: v = 1'b0;
      endcase
      return v;
   endfunction

   assign next_pin0 = sfd_any ? src_s2[4] : pin_pick(mux_reg[pin0_lsb +: 4], src_s2, energy_ok);
   assign next_pin1 = sfd_any ? src_s2[3] : pin_pick(mux_reg[pin1_lsb +: 4], src_s2, energy_ok);

   always_ff @(posedge clk) begin
      if (reset) begin
         pin0_out <= 1'b0;
         pin1_out <= 1'b0;
      end else begin
         pin0_out <= next_pin0;
         pin1_out <= next_pin1;
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   sign_readback_a: assert property (@(posedge clk) disable iff (reset)
      (psel && !penable && !pwrite && paddr == peak_sign_addr) |=> prdata[31:10] == 22'h0 && prdata[9:0] == $past(sign_s2))
      else $error("peak sign readback wrong");
   opmode_follow_a: assert property (@(posedge clk) disable iff (reset)
      (wr && paddr == mode_addr) |=> ##1 operating_mode_code == $past(pwdata[2:0], 2))
      else $error("opmode not applied");
   bridge_follow_a: assert property (@(posedge clk) disable iff (reset)
      ##1 bridge_direction_sel == $past(mode_reg[bridge_bit]))
      else $error("bridge select mismatch");
   mii_follow_a: assert property (@(posedge clk) disable iff (reset)
      (wr && paddr == mode_addr) |=> ##1 mii_select == $past(pwdata[5], 2))
      else $error("mii select not applied");
   pin1_override_a: assert property (@(posedge clk) disable iff (reset)
      sfd_any |=> pin1_out == $past(src_s2[3]))
      else $error("pin1 not forced to transmit delimiter");
   pin0_override_a: assert property (@(posedge clk) disable iff (reset)
      sfd_any |=> pin0_out == $past(src_s2[4]))
      else $error("pin0 not forced to receive delimiter");
   const_high_a: assert property (@(posedge clk) disable iff (reset)
      (!sfd_any && mux_reg[3:0] == fn_high) |=> pin0_out)
      else $error("constant high not driven");
   pin1_wake_a: assert property (@(posedge clk) disable iff (reset)
      (!sfd_any && mux_reg[7:4] == fn_wake) |=> pin1_out == $past(src_s2[5]))
      else $error("pin1 wake selection wrong");
   energy_gate_a: assert property (@(posedge clk) disable iff (reset)
      (!sfd_any && !energy_ok && mux_reg[3:0] == fn_energy) |=> !pin0_out)
      else $error("energy shown outside copper");
endmodule

// >>> sim/tb_pomgr_regs.sv
// testbench for the mode and pin mux register slice
module tb_pomgr_regs
   import pomgr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------
   // signals
   // ----------------
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [4:0] pc = 5'h00;
   logic [4:0] pd = 5'h00;
   logic [11:0] src = 12'h000;
   logic [31:0] prdata;
   logic pready, pslverr, brg, mii, pin0, pin1;
   logic [2:0] opc;
   int bad_count = 0;
   int compares = 0;
   int i;
   logic [3:0] c;
   logic [11:0] s;
   pomgr_regs pomgr_regs_i (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pair_c_peak_polarity(pc), .pair_d_peak_polarity(pd), .clk_out_src(src[0]), .intr_src(src[1]),
      .link_src(src[2]), .transmit_delimiter_pulse(src[3]), .receive_delimiter_pulse(src[4]),
      .wake_on_lan_output(src[5]), .energy_src(src[6]), .prbs_err_src(src[7]),
      .second_indicator_output(src[8]), .third_indicator_output(src[9]), .crs_src(src[10]),
      .col_src(src[11]), .operating_mode_code(opc), .bridge_direction_sel(brg), .mii_select(mii),
      .pin0_out(pin0), .pin1_out(pin1));
   initial begin
      forever #2.5 clk = ~clk;
   end
   // ----------------
   // tasks
   // ----------------
   task automatic test_done();
      $display("compares %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] ed,
                       input logic ee);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) begin
         bad_count++;
         test_done();
      end
      if (!w) chk(prdata, ed);
      chk({31'h0, pslverr}, {31'h0, ee});
   endtask
   task automatic idle();
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic pins(input logic e0, input logic e1);
      int n;
      repeat (4) @(posedge clk);
      n = 0;
      while (!(pin0 === e0 && pin1 === e1) && n < 8) begin
         @(posedge clk);
         n++;
      end
      chk({30'h0, pin1, pin0}, {30'h0, e1, e0});
      if (pin0 !== e0 || pin1 !== e1) test_done();
   endtask
   function automatic logic fval(input logic [3:0] k, input logic [11:0] v, input logic cu);
      case (k)
         fn_clk_out: return v[0];
         fn_intr: return v[1];
         fn_link: return v[2];
         fn_transmit_delimiter_pulse: return v[3];
         fn_receive_delimiter_pulse: return v[4];
         fn_wake: return v[5];
         fn_energy: return v[6] & cu;
         fn_prbs: return v[7];
         fn_ind2: return v[8];
         fn_ind3: return v[9];
         fn_crs: return v[10];
         fn_col: return v[11];
         fn_high: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction
   // ----------------
   // tests
   // ----------------
   initial begin
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      xfer(0, mode_addr, 0, 32'h40, 0);
      xfer(0, pin_mux_addr, 0, 32'h417a, 0);
      xfer(0, peak_sign_addr, 0, 0, 0);
      idle();
      chk({27'h0, brg, mii, opc}, {27'h0, 1'b1, 1'b0, 3'h0});
      $display("reset values done");
      pc <= 5'h15;
      pd <= 5'h0a;
      repeat (4) @(posedge clk);
      xfer(0, peak_sign_addr, 0, 32'h155, 0);
      xfer(1, peak_sign_addr, 32'hffff, 0, 1);
      xfer(0, peak_sign_addr, 0, 32'h155, 0);
      xfer(0, 12'h004, 0, 0, 1);
      $display("peak signs done");
      for (i = 0; i < 7; i++) begin
         xfer(1, mode_addr, {25'h0, i[0], i[1], 2'h0, i[2:0]}, 0, 0);
         xfer(0, mode_addr, 0, {25'h0, i[0], i[1], 2'h0, i[2:0]}, 0);
         chk({27'h0, brg, mii, opc}, {27'h0, i[0], i[1], i[2:0]});
      end
      $display("mode register done");
      xfer(1, mode_addr, 32'h40, 0, 0);
      for (i = 0; i < 32; i++) begin
         c = i[3:0];
         if (c inside {4'h1, 4'h4, 4'hb, 4'he}) continue;
         s = i[4] ? 12'ha5c : 12'h5a3;
         src <= s;
         xfer(1, pin_mux_addr, {16'h0, 8'h41, ~c, c}, 0, 0);
         idle();
         pins(fval(c, s, 1'b1), fval(~c, s, 1'b1));
      end
      src <= 12'hfff;
      xfer(1, mode_addr, 32'h41, 0, 0);
      xfer(1, pin_mux_addr, 32'h4188, 0, 0);
      idle();
      pins(1'b0, 1'b0);
      xfer(1, mode_addr, 32'h45, 0, 0);
      idle();
      pins(1'b1, 1'b1);
      $display("pin functions done");
      src <= 12'h010;
      xfer(1, pin_mux_addr, 32'h41fe, 0, 0);
      for (i = 1; i < 4; i++) begin
         xfer(1, sfd_ctrl_addr, i, 0, 0);
         idle();
         pins(1'b1, 1'b0);
      end
      xfer(1, sfd_ctrl_addr, 0, 0, 0);
      idle();
      pins(1'b0, 1'b1);
      $display("delimiter override done");
      test_done();
   end
endmodule
